// ### rtl/epf_pkg.sv
// Constants, register map and carrier types for the pause flow control block
package epf_pkg;

   // Register bus shape
   localparam int EPF_ADDR_W = 16;
   localparam int EPF_DATA_W = 32;

   // Register offsets (word addresses on the plain port)
   localparam logic [15:0] EPF_REG_RX_EN    = 16'h0700;
   localparam logic [15:0] EPF_REG_FWD      = 16'h0701;
   localparam logic [15:0] EPF_REG_HONOUR   = 16'h0702;
   localparam logic [15:0] EPF_REG_TX_EN    = 16'h0703;
   localparam logic [15:0] EPF_REG_SW_REQ   = 16'h0704;
   localparam logic [15:0] EPF_REG_HOLD_EN  = 16'h0705;
   localparam logic [15:0] EPF_REG_HOLD_Q   = 16'h0706;
   localparam logic [15:0] EPF_REG_ADDR_LO  = 16'h0707;
   localparam logic [15:0] EPF_REG_ADDR_HI  = 16'h0708;
   localparam logic [15:0] EPF_REG_PFC_LO   = 16'h0709;
   localparam logic [15:0] EPF_REG_PFC_HI   = 16'h070A;
   localparam logic [15:0] EPF_REG_TX_Q     = 16'h070B;
   localparam logic [15:0] EPF_REG_STATUS   = 16'h070C;

   // Reset values
   localparam logic        EPF_RST_RX_EN   = 1'b1;
   localparam logic        EPF_RST_FWD     = 1'b0;
   localparam logic        EPF_RST_HONOUR  = 1'b1;
   localparam logic        EPF_RST_HOLD_EN = 1'b1;
   localparam logic [15:0] EPF_RST_HOLD_Q  = 16'h0100;
   localparam logic [15:0] EPF_RST_TX_Q    = 16'hFFFF;
   localparam logic [47:0] EPF_RST_ADDR    = 48'h0180C2000001;

   // Field positions and frame codes
   localparam int          EPF_HONOUR_BIT = 0;
   localparam int          EPF_MCAST_BIT  = 40;
   localparam int          EPF_STAT_PEND  = 16;
   localparam logic [15:0] EPF_ETYPE_PAUSE = 16'h8808;
   localparam logic [15:0] EPF_OPC_STD     = 16'h0001;
   localparam logic [15:0] EPF_OPC_PFC     = 16'h0101;

   // Class limits and quanta width
   localparam int EPF_MAX_CLS = 8;
   localparam int EPF_CLS_W   = 3;
   localparam int EPF_Q_W     = 16;

   // Quantum timing: 512 bit times at the link rate, in mclk cycles
   localparam int EPF_QUANTUM_BITS = 512;
   localparam int EPF_LINK_MBPS    = 100000;
   localparam int EPF_CLK_PERIOD_NS = 100;
   localparam int EPF_QUANTUM_PS =
      EPF_QUANTUM_BITS * 1000000 / EPF_LINK_MBPS;
   localparam int EPF_QUANTUM_RAW =
      EPF_QUANTUM_PS / (EPF_CLK_PERIOD_NS * 1000);
   localparam int EPF_QUANTUM_CYC =
      (EPF_QUANTUM_RAW < 1) ? 1 : EPF_QUANTUM_RAW;

   // Flow control mode
   typedef enum logic {
      EPF_STD = 1'b0,
      EPF_PFC = 1'b1
   } epf_mode_t;

   // Pause frame request handed to the TX MAC
   typedef struct packed {
      logic                 xoff;
      logic [EPF_CLS_W-1:0] cls;
      logic [EPF_Q_W-1:0]   quanta;
   } epf_req_t;

   // Parsed header of a received control frame
   typedef struct packed {
      logic [47:0]            dst;
      logic [15:0]            etype;
      logic [15:0]            opcode;
      logic [EPF_MAX_CLS-1:0] cls_en;
      logic                   runt;
      logic                   fcs_err;
   } epf_rx_info_t;

endpackage

// ### rtl/epf_pause_ctrl.sv
// Pause frame generation, filtering and pause timing for one MAC
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module epf_pause_ctrl #(
   parameter int                 N              = 1,
   parameter epf_pkg::epf_mode_t MODE           = epf_pkg::EPF_STD,
   parameter bit                 IGNORE_BAD_STD = 1'b1
) (
   // Clock and reset
   input  wire logic                           mclk,
   input  wire logic                           rst_n,
   // Register port
   input  wire logic [epf_pkg::EPF_ADDR_W-1:0] reg_addr,
   input  wire logic [epf_pkg::EPF_DATA_W-1:0] reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [epf_pkg::EPF_DATA_W-1:0] reg_rdata,
   // Client pause requests
   input  wire logic [N-1:0]                   pause_req_in,
   // Pause frame requests to the TX MAC
   input  wire logic                           tx_frame_active,
   output logic                                tx_pf_valid,
   input  wire logic                           tx_pf_ready,
   output epf_pkg::epf_req_t                   tx_pf_req,
   // Throttle to the TX MAC, one bit per class
   output logic      [N-1:0]                   tx_throttle,
   // Received control frame verdicts
   input  wire logic                           rx_pf_valid,
   input  wire epf_pkg::epf_rx_info_t          rx_pf_info,
   input  wire logic [epf_pkg::EPF_Q_W-1:0]    rx_pf_quanta [N],
   output logic                                rx_drop,
   output logic                                rx_deliver,
   output logic      [N-1:0]                   pause_receive_rx
);
   import epf_pkg::*;

   // Lowest set bit of a class vector: {found, index}
   function automatic logic [EPF_CLS_W:0] pick_lowest(
      input logic [N-1:0] v);
      logic [EPF_CLS_W:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, EPF_CLS_W'(i)};
         end
      end
      return r;
   endfunction

   // Software visible registers
   logic                 rx_en_reg;      // Pause processing enable
   logic                 fwd_reg;        // Forward matching pauses
   logic                 honour_reg;     // Standard mode TX honour
   logic [N-1:0]         tx_en_reg;      // Per class XOFF and XON enable
   logic [N-1:0]         sw_req_reg;     // Software pause request
   logic                 hold_en_reg;    // Retransmission enable
   logic [EPF_Q_W-1:0]   hold_q_reg;     // Retransmit hold-off quanta
   logic [EPF_Q_W-1:0]   tx_q_reg;       // Quanta sent in XOFF
   logic [31:0]          addr_lo_reg;    // Standard match address low
   logic [15:0]          addr_hi_reg;    // Standard match address high
   logic [31:0]          pfc_lo_reg;     // Priority match address low
   logic [15:0]          pfc_hi_reg;     // Priority match address high

   // Generation state
   logic [N-1:0]         req_d_reg;      // Request seen last cycle
   logic [N-1:0]         pend_xoff_reg;  // XOFF waiting per class
   logic [N-1:0]         pend_xon_reg;   // XON waiting per class
   logic [EPF_Q_W-1:0]   hold_cnt_reg [N];
   logic [15:0]          qdiv_reg;       // Quantum prescaler

   // Two entry buffer toward the TX MAC
   logic [1:0]           cnt_reg;
   epf_req_t             head_reg;
   epf_req_t             tail_reg;

   // Receive state
   logic [EPF_Q_W-1:0]   pause_cnt_reg [N];

   // Combinational terms
   logic [N-1:0]         req_c;
   logic [N-1:0]         rise;
   logic [N-1:0]         fall;
   logic [N-1:0]         retx;
   logic [EPF_CLS_W:0]   xoff_pick;
   logic [EPF_CLS_W:0]   xon_pick;
   logic                 push;
   logic                 pop;
   epf_req_t             push_req;
   logic                 qtick;
   logic                 is_pause;
   logic                 addr_ok;
   logic                 bad_skip;
   logic                 process;
   logic                 drop_c;
   logic [47:0]          match_addr;
   logic [N-1:0]         cls_hit;
   logic                 allow;

   // Quantum tick, shared by both timer kinds
   assign qtick = (qdiv_reg == 16'(EPF_QUANTUM_CYC - 1));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         qdiv_reg <= '0;
      end else if (qtick) begin
         qdiv_reg <= '0;
      end else begin
         qdiv_reg <= qdiv_reg + 16'h0001;
      end
   end

   // Register writes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_en_reg   <= EPF_RST_RX_EN;
         fwd_reg     <= EPF_RST_FWD;
         honour_reg  <= EPF_RST_HONOUR;
         tx_en_reg   <= '1;
         sw_req_reg  <= '0;
         hold_en_reg <= EPF_RST_HOLD_EN;
         hold_q_reg  <= EPF_RST_HOLD_Q;
         tx_q_reg    <= EPF_RST_TX_Q;
         addr_lo_reg <= EPF_RST_ADDR[31:0];
         addr_hi_reg <= EPF_RST_ADDR[47:32];
         pfc_lo_reg  <= EPF_RST_ADDR[31:0];
         pfc_hi_reg  <= EPF_RST_ADDR[47:32];
      end else if (reg_wr) begin
         case (reg_addr)
            EPF_REG_RX_EN:   rx_en_reg   <= reg_wdata[0];
            EPF_REG_FWD:     fwd_reg     <= reg_wdata[0];
            EPF_REG_HONOUR:  honour_reg  <= reg_wdata[EPF_HONOUR_BIT];
            EPF_REG_TX_EN:   tx_en_reg   <= reg_wdata[N-1:0];
            EPF_REG_SW_REQ:  sw_req_reg  <= reg_wdata[N-1:0];
            EPF_REG_HOLD_EN: hold_en_reg <= reg_wdata[0];
            EPF_REG_HOLD_Q:  hold_q_reg  <= reg_wdata[EPF_Q_W-1:0];
            EPF_REG_TX_Q:    tx_q_reg    <= reg_wdata[EPF_Q_W-1:0];
            EPF_REG_ADDR_LO: addr_lo_reg <= reg_wdata;
            EPF_REG_ADDR_HI: addr_hi_reg <= reg_wdata[15:0];
            EPF_REG_PFC_LO:  pfc_lo_reg  <= reg_wdata;
            EPF_REG_PFC_HI:  pfc_hi_reg  <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // Register reads, data valid in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         case (reg_addr)
            EPF_REG_RX_EN:   reg_rdata[0]         <= rx_en_reg;
            EPF_REG_FWD:     reg_rdata[0]         <= fwd_reg;
            EPF_REG_HONOUR:  reg_rdata[EPF_HONOUR_BIT] <= honour_reg;
            EPF_REG_TX_EN:   reg_rdata[N-1:0]     <= tx_en_reg;
            EPF_REG_SW_REQ:  reg_rdata[N-1:0]     <= sw_req_reg;
            EPF_REG_HOLD_EN: reg_rdata[0]         <= hold_en_reg;
            EPF_REG_HOLD_Q:  reg_rdata[EPF_Q_W-1:0] <= hold_q_reg;
            EPF_REG_TX_Q:    reg_rdata[EPF_Q_W-1:0] <= tx_q_reg;
            EPF_REG_ADDR_LO: reg_rdata            <= addr_lo_reg;
            EPF_REG_ADDR_HI: reg_rdata[15:0]      <= addr_hi_reg;
            EPF_REG_PFC_LO:  reg_rdata            <= pfc_lo_reg;
            EPF_REG_PFC_HI:  reg_rdata[15:0]      <= pfc_hi_reg;
            // Live throttle state and pending XOFF classes
            EPF_REG_STATUS: begin
               reg_rdata[N-1:0] <= tx_throttle;
               reg_rdata[EPF_STAT_PEND +: N] <= pend_xoff_reg;
            end
            default: ;                       // Unmapped reads zero
         endcase
      end
   end

   // Request edges; client and software requests are merged per class
   assign req_c = pause_req_in | sw_req_reg;
   assign rise  = req_c & ~req_d_reg;
   assign fall  = ~req_c & req_d_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_d_reg <= '0;
      end else begin
         req_d_reg <= req_c;
      end
   end

   // Retransmit when hold-off lapses with the request still high
   always_comb begin
      for (int n = 0; n < N; n++) begin
         retx[n] = hold_en_reg && req_c[n] && qtick
                   && (hold_cnt_reg[n] == 16'h0001);
      end
   end

   // Scheduler: XOFF ahead of XON, lowest class first
   assign xoff_pick = pick_lowest(pend_xoff_reg);
   assign xon_pick  = pick_lowest(pend_xon_reg);

   always_comb begin
      push_req = '0;
      if (xoff_pick[EPF_CLS_W]) begin
         push_req.xoff   = 1'b1;
         push_req.cls    = xoff_pick[EPF_CLS_W-1:0];
         push_req.quanta = tx_q_reg;
      end else begin
         push_req.cls    = xon_pick[EPF_CLS_W-1:0];   // XON carries zero
      end
   end

   // Full buffer stalls the scheduler; pending bits keep the events
   assign push = (xoff_pick[EPF_CLS_W] || xon_pick[EPF_CLS_W])
                 && (cnt_reg != 2'd2);

   // Pending flags; a new event wins over the clear by a push
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend_xoff_reg <= '0;
         pend_xon_reg  <= '0;
      end else begin
         for (int n = 0; n < N; n++) begin
            if ((rise[n] || retx[n]) && tx_en_reg[n]) begin
               pend_xoff_reg[n] <= 1'b1;
            end else if (fall[n] || (push && push_req.xoff
                         && push_req.cls == EPF_CLS_W'(n))) begin
               pend_xoff_reg[n] <= 1'b0;
            end
            if (fall[n] && tx_en_reg[n]) begin
               pend_xon_reg[n] <= 1'b1;
            end else if (rise[n] || (push && !push_req.xoff
                         && push_req.cls == EPF_CLS_W'(n))) begin
               pend_xon_reg[n] <= 1'b0;
            end
         end
      end
   end

   // Hold-off timers, reloaded each time an XOFF leaves the scheduler
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int n = 0; n < N; n++) begin
            hold_cnt_reg[n] <= '0;
         end
      end else begin
         for (int n = 0; n < N; n++) begin
            if (push && push_req.xoff
                && push_req.cls == EPF_CLS_W'(n)) begin
               hold_cnt_reg[n] <= hold_q_reg;
            end else if (!req_c[n]) begin
               hold_cnt_reg[n] <= '0;
            end else if (qtick && hold_cnt_reg[n] != '0) begin
               hold_cnt_reg[n] <= hold_cnt_reg[n] - 16'h0001;
            end
         end
      end
   end

   // Buffer: head is the output word, tail the spare slot
   assign pop         = tx_pf_valid && tx_pf_ready;
   assign tx_pf_valid = (cnt_reg != 2'd0) && !tx_frame_active;
   assign tx_pf_req   = head_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_reg <= 2'd0;
      end else if (push && !pop) begin
         cnt_reg <= cnt_reg + 2'd1;
      end else if (pop && !push) begin
         cnt_reg <= cnt_reg - 2'd1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         head_reg <= '0;
         tail_reg <= '0;
      end else begin
         if (cnt_reg == 2'd2 && pop) begin
            head_reg <= tail_reg;            // Full: spare moves up
         end else if (push && (cnt_reg == 2'd0 || pop)) begin
            head_reg <= push_req;
         end else if (push) begin
            tail_reg <= push_req;
         end
      end
   end

   // Receive filter
   assign match_addr = (MODE == EPF_PFC) ? {pfc_hi_reg, pfc_lo_reg}
                                         : {addr_hi_reg, addr_lo_reg};
   assign is_pause = (rx_pf_info.etype == EPF_ETYPE_PAUSE)
                     && (rx_pf_info.opcode == ((MODE == EPF_PFC)
                         ? EPF_OPC_PFC : EPF_OPC_STD));
   assign addr_ok  = (rx_pf_info.dst == match_addr)
                     || rx_pf_info.dst[EPF_MCAST_BIT];
   // Bad standard frames never pause us on such targets
   assign bad_skip = IGNORE_BAD_STD && (MODE == EPF_STD)
                     && (rx_pf_info.runt || rx_pf_info.fcs_err);
   assign process  = rx_pf_valid && is_pause && addr_ok
                     && rx_en_reg && !bad_skip;
   // Drop verdict looks at no error flag, so bad frames forward too
   assign drop_c   = rx_pf_valid && is_pause && addr_ok
                     && (!rx_en_reg || !fwd_reg);

   always_comb begin
      for (int n = 0; n < N; n++) begin
         cls_hit[n] = (MODE == EPF_PFC) ? rx_pf_info.cls_en[n] : (n == 0);
      end
   end

   // Frame verdicts, one cycle after the frame header
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_drop    <= 1'b0;
         rx_deliver <= 1'b0;
      end else begin
         rx_drop    <= drop_c;
         rx_deliver <= rx_pf_valid && !drop_c;
      end
   end

   // Match pulses per class
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pause_receive_rx <= '0;
      end else begin
         pause_receive_rx <= process ? cls_hit : '0;
      end
   end

   // Pause timers: reload replaces any running count, zero resumes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int n = 0; n < N; n++) begin
            pause_cnt_reg[n] <= '0;
         end
      end else begin
         for (int n = 0; n < N; n++) begin
            if (process && cls_hit[n]) begin
               pause_cnt_reg[n] <= rx_pf_quanta[n];
            end else if (qtick && pause_cnt_reg[n] != '0) begin
               pause_cnt_reg[n] <= pause_cnt_reg[n] - 16'h0001;
            end
         end
      end
   end

   // Throttle level; the TX MAC checks it only between frames
   assign allow = (MODE == EPF_PFC) || honour_reg;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_throttle <= '0;
      end else begin
         for (int n = 0; n < N; n++) begin
            tx_throttle[n] <= allow
                              && (pause_cnt_reg[n] != '0);
         end
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_tx_after_frame: assert property (
      tx_pf_valid |-> !tx_frame_active)
      else $error("pause request offered during a frame");

   a_xoff_on_rise: assert property (
      (rise[0] && tx_en_reg[0] && cnt_reg == 2'd0 && !fall[0])
      |=> push && push_req.xoff && push_req.cls == '0)
      else $error("request rise did not schedule an XOFF");

   a_xon_on_fall: assert property (
      (fall[0] && tx_en_reg[0] && cnt_reg == 2'd0 && N == 1)
      |=> push && !push_req.xoff && push_req.quanta == '0)
      else $error("request fall did not schedule an XON");

   a_xoff_needs_req: assert property (
      (retx[0] && tx_en_reg[0]) |=> pend_xoff_reg[0] ##0 req_d_reg[0])
      else $error("retransmit fired without a held request");

   a_match_pulse: assert property (
      (process && cls_hit[0]) |=> pause_receive_rx[0])
      else $error("matched pause missing its class pulse");

   a_disabled_quiet: assert property (
      (rx_pf_valid && !rx_en_reg) |=> pause_receive_rx == '0)
      else $error("pause processed while processing disabled");

   a_bad_ignored: assert property (
      (rx_pf_valid && bad_skip) |=> pause_receive_rx == '0)
      else $error("bad standard pause frame was processed");

   a_unmatched_out: assert property (
      (rx_pf_valid && is_pause && !addr_ok) |=> rx_deliver && !rx_drop)
      else $error("unmatched pause frame was not delivered");

   a_honour_gate: assert property (
      (MODE == EPF_STD && !honour_reg) |=> tx_throttle == '0)
      else $error("throttle raised with honour bit clear");

   a_timer_reload: assert property (
      (process && cls_hit[0])
      |=> pause_cnt_reg[0] == $past(rx_pf_quanta[0]))
      else $error("pause timer not reloaded by new quanta");

endmodule // epf_pause_ctrl

// ### verification/epf_tx_mac_model.sv
// Model of the TX MAC that sends frames and takes pause requests
`timescale 1ns/1ps
module epf_tx_mac_model (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // Pause request handshake
   input  wire logic tx_pf_valid,
   input  wire logic slow,
   output logic      tx_frame_active,
   output logic      tx_pf_ready
);
   logic [3:0] left_reg; // Cycles left in the frame on the wire

   // Frames go out whole; a pause frame waits for the gap
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         left_reg        <= 4'h0;
         tx_frame_active <= 1'b0;
      end else if (left_reg != 4'h0) begin
         left_reg        <= left_reg - 4'h1;
         tx_frame_active <= (left_reg != 4'h1);
      end else if (tx_pf_valid && tx_pf_ready) begin
         left_reg        <= 4'h2;      // The accepted pause frame itself
         tx_frame_active <= 1'b1;
      end else if ($urandom % 4 == 0) begin
         left_reg        <= 4'(1 + $urandom % 6);
         tx_frame_active <= 1'b1;
      end
   end

   // Slow mode stalls requests at random, like a busy MAC
   always_ff @(posedge mclk) begin
      tx_pf_ready <= rst_n && (!slow || $urandom % 2 == 0);
   end
endmodule // epf_tx_mac_model

// ### verification/tb_epf_pause_ctrl.sv
// Self-checking bench for the pause flow control block
`timescale 1ns/1ps
module tb_epf_pause_ctrl;
   import epf_pkg::*;
   logic mclk, rst_n, reg_wr, reg_rd, tx_frame_active, tx_pf_ready;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [0:0] pause_req_in, tx_throttle, pause_receive_rx;
   logic tx_pf_valid, rx_pf_valid, rx_drop, rx_deliver, slow, rd_d;
   epf_req_t tx_pf_req;
   epf_rx_info_t rx_pf_info;
   logic [15:0] rx_pf_quanta [1];
   logic [31:0] rq[$];  // Expected read data
   epf_req_t tq[$];     // Expected pause frame requests
   logic [3:0] xq[$];   // Expected drop, deliver, match, throttle
   logic thr_e, thr_chk;
   int errors, checks, xoffs, n;
   bit retx;            // Count repeated XOFFs instead of matching
   logic [15:0] ra [10] = '{16'h0700, 16'h0701, 16'h0702, 16'h0707,
                            16'h0708, 16'h07FF, 16'h0703, 16'h0705,
                            16'h0706, 16'h070B};
   logic [31:0] rv [10] = '{32'h1, 32'h0, 32'h1, 32'hC2000001,
                            32'h0180, 32'h0, 32'h1, 32'h1,
                            32'h0100, 32'hFFFF};
   localparam logic [47:0] MA = 48'h002233445566; // Unicast match value

   epf_pause_ctrl #(.N(1)) epf_pause_ctrl_i (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pause_req_in(pause_req_in),
      .tx_frame_active(tx_frame_active), .tx_pf_valid(tx_pf_valid),
      .tx_pf_ready(tx_pf_ready), .tx_pf_req(tx_pf_req),
      .tx_throttle(tx_throttle), .rx_pf_valid(rx_pf_valid),
      .rx_pf_info(rx_pf_info), .rx_pf_quanta(rx_pf_quanta),
      .rx_drop(rx_drop), .rx_deliver(rx_deliver),
      .pause_receive_rx(pause_receive_rx));
   epf_tx_mac_model epf_tx_mac_model_i (
      .mclk(mclk), .rst_n(rst_n), .tx_pf_valid(tx_pf_valid),
      .slow(slow), .tx_frame_active(tx_frame_active),
      .tx_pf_ready(tx_pf_ready));

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string m);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task finish_test;
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Register cycles; a spare edge keeps strobes from being set twice
   task wr(input logic [15:0] a, input logic [31:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge mclk) reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [15:0] a, input logic [31:0] e);
      rq.push_back(e); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge mclk) reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   // Bounded wait for every expected pause request to go out
   task drain;
      for (int i = 0; i < 300 && (tq.size() != 0 || tx_pf_valid); i++)
         @(posedge mclk);
      if (tq.size() != 0) begin
         errors++;
         finish_test();
      end
      repeat (10) @(posedge mclk);
   endtask
   task send(input logic v, input logic x);
      if (x) tq.push_back('{v, 3'h0, v ? EPF_RST_TX_Q : 16'h0});
      pause_req_in <= v;
      @(posedge mclk) drain();
   endtask
   // One received standard pause header, quanta 2 to 5
   task frame(input logic [47:0] d, input logic bad, input logic [3:0] e);
      xq.push_back(e);
      rx_pf_info <= '{d, EPF_ETYPE_PAUSE, EPF_OPC_STD, 8'h01, 1'b0, bad};
      rx_pf_quanta[0] <= 16'(2 + $urandom % 4);
      rx_pf_valid <= 1'b1;
      @(posedge mclk) rx_pf_valid <= 1'b0;
      repeat (10) @(posedge mclk);
   endtask

   // Monitor: each result takes the oldest note off its queue, except XOFFs counted while retx is set
   always @(posedge mclk) begin
      rd_d <= reg_rd;
      thr_chk <= rx_drop === 1'b1 || rx_deliver === 1'b1;
      if (rd_d === 1'b1) chk(reg_rdata, rq.pop_front(), "read");
      if (tx_pf_valid === 1'b1 && tx_pf_ready === 1'b1) begin
         chk(32'(tx_frame_active), 32'h0, "mid frame");
         if (retx && tx_pf_req.xoff === 1'b1) xoffs++;
         else chk(32'(tx_pf_req), 32'(tq.pop_front()), "req");
      end
      if (rx_drop === 1'b1 || rx_deliver === 1'b1) begin
         thr_e <= xq[0][0];
         chk(32'({rx_drop, rx_deliver, pause_receive_rx}),
             32'(xq.pop_front() >> 1), "verdict");
      end
      if (thr_chk) chk(32'(tx_throttle), 32'(thr_e), "thr");
   end

   initial begin
      {rst_n, reg_wr, reg_rd, rx_pf_valid, slow} = '0;
      {reg_addr, reg_wdata, pause_req_in, rx_pf_info} = '0;
      rx_pf_quanta[0] = 16'h0;
      retx = 1'b0;
      void'($urandom(32'hF02D4D50));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      foreach (ra[i]) rd(ra[i], rv[i]);
      wr(EPF_REG_HOLD_EN, 32'h0);
      send(1'b1, 1'b1);
      send(1'b0, 1'b1);
      slow <= 1'b1;
      tq.push_back('{1'b1, 3'h0, EPF_RST_TX_Q});
      wr(EPF_REG_SW_REQ, 32'h1);
      drain();
      tq.push_back('{1'b0, 3'h0, 16'h0});
      wr(EPF_REG_SW_REQ, 32'h0);
      drain();
      wr(EPF_REG_TX_EN, 32'h0);
      send(1'b1, 1'b0);
      send(1'b0, 1'b0);
      wr(EPF_REG_TX_EN, 32'h1);
      wr(EPF_REG_HOLD_EN, 32'h1);
      wr(EPF_REG_HOLD_Q, 32'h3);
      retx = 1'b1;
      xoffs = 0;
      pause_req_in <= 1'b1;
      repeat (80) @(posedge mclk);
      chk(32'(xoffs > 3), 32'h1, "repeat");
      send(1'b0, 1'b1);
      n = xoffs;
      repeat (30) @(posedge mclk);
      chk(xoffs, n, "repeat after drop");
      retx = 1'b0;
      wr(EPF_REG_ADDR_LO, MA[31:0]);
      wr(EPF_REG_ADDR_HI, 32'(MA[47:32]));
      frame(MA, 1'b0, 4'b1011);
      wr(EPF_REG_FWD, 32'h1);
      frame(MA, 1'b0, 4'b0111);
      frame(MA, 1'b1, 4'b0100);
      wr(EPF_REG_FWD, 32'h0);
      frame(MA, 1'b1, 4'b1000);
      frame({16'h0A00, $urandom()}, 1'b0, 4'b0100);
      frame({16'h0B00, $urandom()}, 1'b0, 4'b1011);
      wr(EPF_REG_HONOUR, 32'h0);
      frame(MA, 1'b0, 4'b1010);
      wr(EPF_REG_RX_EN, 32'h0);
      frame(MA, 1'b0, 4'b1000);
      chk(32'(xq.size()), 32'h0, "missing verdict");
      finish_test();
   end
endmodule // tb_epf_pause_ctrl
